/* File: gtpi_timer.sv */
`timescale 1ns/1ps
// How it works
// - Gated mode counts only the bus clock.
// - Gate rising edge starts prescaled counting.
// - Count equal to period wraps to zero.
// - Gated mode produces no match event.
// - Gate falling edge: event, stop, keep count.
// - Ratio N advances every Nth cycle.
// - Prescale select gives 1, 8, 64, 256.
// - Prescaler clears on reset, disable, count write.
// - External prescaler resync takes two clock edges.
// - External slow mode waits after enable.
// - Match value held N/2 ticks (one tick for N=1) before wrap.
// - Match or gate event can interrupt.
// - Flag set one cycle after the event, interrupt one cycle later.
// - Interrupt only while enable bit set.
// - Priority and subpriority; priority zero blocks interrupt.
// - Pin claimed only in gated/external sync modes.
module gtpi_timer (
  input wire logic mclk,
  input wire logic reset,
  input wire gtpi_pkg::gtpi_bus_req_t bus_req,
  input wire logic ext_clock_gate_pin,
  output logic [31:0] rdata,
  output logic irq,
  output logic gate_pin_claimed
);
  import gtpi_pkg::*;

  gtpi_core_state_t st_r;
  gtpi_core_state_t st_nxt;

  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  logic ps_inc;
  logic ps_clr;
  logic gated;
  logic src_tick;
  logic tick_ok;
  logic slow_ext;
  logic count_wr;
  logic flags_rd;
  logic match_evt;
  logic gate_evt;
  logic [8:0] ratio;
  logic [7:0] hold_len;

  gtpi_gate_sync u_sync (
    .mclk(mclk),
    .reset(reset),
    .din(ext_clock_gate_pin),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  gtpi_prescale #(
    .CNT_W(8)
  ) u_prescale (
    .mclk(mclk),
    .reset(reset),
    .clr(ps_clr),
    .tick(tick_ok),
    .sel(st_r.ctrl.prescale_select),
    .inc(ps_inc)
  );

  // Gating applies only with the internal clock selected; the sync setting plays no part.
  assign gated = st_r.ctrl.gate_enable & ~st_r.ctrl.clock_source_select;
  assign src_tick = st_r.ctrl.clock_source_select ? pin_rise : 1'b1;
  // A cleared on bit stops counting at once rather than one cycle later.
  assign tick_ok = st_r.ctrl.timer_on & src_tick & (~gated | st_r.gate_open);
  assign ratio = gtpi_ratio(st_r.ctrl.prescale_select);
  assign hold_len = (ratio == 9'h001) ? 8'h01 : 8'(ratio >> 1);
  assign slow_ext = st_r.ctrl.clock_source_select & (ratio != 9'h001);
  assign count_wr = bus_req.wr & (bus_req.addr == GTPI_OFS_COUNT);
  assign flags_rd = bus_req.rd & (bus_req.addr == GTPI_OFS_FLAGS);

  // The prescaler is held clear outside normal counting, so a wrap or a
  // resync always restarts a full prescale period.
  assign ps_clr = (st_r.fsm != GTPI_ST_RUN) | ~st_r.ctrl.timer_on | count_wr;

  assign match_evt = (st_r.fsm == GTPI_ST_RUN) & ps_inc & ~gated & ~count_wr &
                     (st_r.count != st_r.period) &
                     (16'(st_r.count + 16'h0001) == st_r.period);
  assign gate_evt = st_r.ctrl.timer_on & gated & st_r.gate_open & pin_fall;

  always_comb begin
    st_nxt = st_r;

    case (st_r.fsm)
      GTPI_ST_IDLE: begin
        if (st_r.ctrl.timer_on) begin
          st_nxt.resync_cnt = 2'h0;
          st_nxt.fsm = slow_ext ? GTPI_ST_RESYNC : GTPI_ST_RUN;
        end
      end
      GTPI_ST_RESYNC: begin
        if (pin_rise) begin
          if (st_r.resync_cnt == GTPI_RESYNC_TICKS - 2'h1) begin
            st_nxt.fsm = GTPI_ST_RUN;
          end else begin
            st_nxt.resync_cnt = st_r.resync_cnt + 2'h1;
          end
        end
      end
      GTPI_ST_RUN: begin
        if (st_r.count == st_r.period) begin
          if (tick_ok) begin
            if (hold_len == 8'h01) begin
              st_nxt.count = GTPI_COUNT_RESET;
            end else begin
              st_nxt.hold_cnt = hold_len - 8'h01;
              st_nxt.fsm = GTPI_ST_HOLD;
            end
          end
        end else if (ps_inc) begin
          st_nxt.count = st_r.count + 16'h0001;
        end
      end
      GTPI_ST_HOLD: begin
        if (tick_ok) begin
          if (st_r.hold_cnt == 8'h01) begin
            st_nxt.count = GTPI_COUNT_RESET;
            st_nxt.fsm = GTPI_ST_RUN;
          end else begin
            st_nxt.hold_cnt = st_r.hold_cnt - 8'h01;
          end
        end
      end
      default: begin
        st_nxt.fsm = GTPI_ST_IDLE;
      end
    endcase

    // The gate opens on a rising edge and closes on a falling one; the count
    // is left where it stopped for software to collect.
    if (!st_r.ctrl.timer_on || !gated) begin
      st_nxt.gate_open = 1'b0;
    end else if (pin_rise) begin
      st_nxt.gate_open = 1'b1;
    end else if (pin_fall) begin
      st_nxt.gate_open = 1'b0;
    end

    if (!st_r.ctrl.timer_on) begin
      st_nxt.fsm = GTPI_ST_IDLE;
    end

    // Register writes.
    if (bus_req.wr) begin
      case (bus_req.addr)
        GTPI_OFS_CTRL: begin
          st_nxt.ctrl.timer_on = bus_req.wdata[GTPI_CTRL_ON_BIT];
          st_nxt.ctrl.gate_enable = bus_req.wdata[GTPI_CTRL_GATE_BIT];
          st_nxt.ctrl.prescale_select = bus_req.wdata[GTPI_CTRL_PS_LSB +: 2];
          st_nxt.ctrl.external_sync_enable = bus_req.wdata[GTPI_CTRL_SYNC_BIT];
          st_nxt.ctrl.clock_source_select = bus_req.wdata[GTPI_CTRL_SRC_BIT];
        end
        GTPI_OFS_COUNT: begin
          // A slow external clock needs the prescaler resynchronised first.
          st_nxt.count = bus_req.wdata[15:0];
          st_nxt.resync_cnt = 2'h0;
          if (st_r.ctrl.timer_on) begin
            st_nxt.fsm = slow_ext ? GTPI_ST_RESYNC : GTPI_ST_RUN;
          end
        end
        GTPI_OFS_PERIOD: begin
          st_nxt.period = bus_req.wdata[15:0];
        end
        GTPI_OFS_ENABLE: begin
          st_nxt.ie = bus_req.wdata[1:0];
        end
        GTPI_OFS_PRIO: begin
          st_nxt.prio = bus_req.wdata[GTPI_PRIO_LSB +: 3];
          st_nxt.subprio = bus_req.wdata[GTPI_SUBPRIO_LSB +: 2];
        end
        default: begin
        end
      endcase
    end

    // Reading the flag word clears it; an event in that same cycle survives.
    st_nxt.status = (flags_rd ? 2'h0 : st_r.status) |
                    {gate_evt, match_evt};

    // Read data appear in the cycle after the strobe and read zero elsewhere.
    st_nxt.rdata = 32'h0000_0000;
    if (bus_req.rd) begin
      case (bus_req.addr)
        GTPI_OFS_CTRL: begin
          st_nxt.rdata[GTPI_CTRL_ON_BIT] = st_r.ctrl.timer_on;
          st_nxt.rdata[GTPI_CTRL_GATE_BIT] = st_r.ctrl.gate_enable;
          st_nxt.rdata[GTPI_CTRL_PS_LSB +: 2] = st_r.ctrl.prescale_select;
          st_nxt.rdata[GTPI_CTRL_SYNC_BIT] = st_r.ctrl.external_sync_enable;
          st_nxt.rdata[GTPI_CTRL_SRC_BIT] = st_r.ctrl.clock_source_select;
        end
        GTPI_OFS_COUNT: begin
          st_nxt.rdata[15:0] = st_r.count;
        end
        GTPI_OFS_PERIOD: begin
          st_nxt.rdata[15:0] = st_r.period;
        end
        GTPI_OFS_FLAGS: begin
          st_nxt.rdata[1:0] = st_r.status;
        end
        GTPI_OFS_ENABLE: begin
          st_nxt.rdata[1:0] = st_r.ie;
        end
        GTPI_OFS_PRIO: begin
          st_nxt.rdata[GTPI_PRIO_LSB +: 3] = st_r.prio;
          st_nxt.rdata[GTPI_SUBPRIO_LSB +: 2] = st_r.subprio;
        end
        default: begin
        end
      endcase
    end

    // Subpriority only orders service at the controller; it never gates.
    st_nxt.irq = (|(st_r.status & st_r.ie)) & (st_r.prio != GTPI_PRIO_OFF);

    st_nxt.claimed = st_r.ctrl.timer_on &
                     (gated | (st_r.ctrl.clock_source_select &
                               st_r.ctrl.external_sync_enable));
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= GTPI_CORE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign irq = st_r.irq;
  assign gate_pin_claimed = st_r.claimed;

  chk_gated_no_match: assert property (
    @(posedge mclk) disable iff (reset)
    gated |=> !st_r.status[GTPI_EVT_MATCH_BIT] || $past(st_r.status[GTPI_EVT_MATCH_BIT]))
  else $error("Match flag set in gated mode.");

  chk_wrap_zero: assert property (
    @(posedge mclk) disable iff (reset)
    (st_r.fsm == GTPI_ST_RUN && st_r.count == st_r.period && tick_ok &&
     hold_len == 8'h01 && !count_wr) |=> st_r.count == 16'h0000)
  else $error("Count did not wrap after matching the period.");

  chk_gate_hold_count: assert property (
    @(posedge mclk) disable iff (reset)
    gate_evt ##1 (!count_wr && !pin_rise) |=> $stable(st_r.count))
  else $error("Count moved after the gate closed.");

  chk_flag_latency: assert property (
    @(posedge mclk) disable iff (reset)
    (match_evt || gate_evt) |=> (st_r.status != 2'h0) ##1 (st_r.irq == ($past(st_r.prio) != GTPI_PRIO_OFF &&
      |($past(st_r.status) & $past(st_r.ie)))))
  else $error("Event flag late or interrupt mismatched.");

  chk_irq_enable: assert property (
    @(posedge mclk) disable iff (reset)
    ((st_r.status & st_r.ie) == 2'h0) |=> !st_r.irq)
  else $error("Interrupt raised with no enabled flag.");

  chk_prio_zero: assert property (
    @(posedge mclk) disable iff (reset)
    (st_r.prio == GTPI_PRIO_OFF) |=> !st_r.irq)
  else $error("Interrupt raised at priority zero.");

  chk_pin_claim: assert property (
    @(posedge mclk) disable iff (reset)
    (!st_r.ctrl.timer_on || (!gated && !st_r.ctrl.clock_source_select)) |=> !gate_pin_claimed)
  else $error("Pin claimed outside gated or external modes.");

  chk_resync_stall: assert property (
    @(posedge mclk) disable iff (reset)
    (st_r.fsm == GTPI_ST_RESYNC && !count_wr) |=> $stable(st_r.count))
  else $error("Count advanced during prescaler resync.");

  chk_hold_value: assert property (
    @(posedge mclk) disable iff (reset)
    (st_r.fsm == GTPI_ST_HOLD && !count_wr && !bus_req.wr) |=>
      $stable(st_r.count) || st_r.count == 16'h0000)
  else $error("Count left the match value during hold.");

  chk_flag_sticky: assert property (
    @(posedge mclk) disable iff (reset)
    (st_r.status[GTPI_EVT_GATE_BIT] && !flags_rd) |=> st_r.status[GTPI_EVT_GATE_BIT])
  else $error("Gate flag cleared without a read.");

  chk_disable_stops_count: assert property (
    @(posedge mclk) disable iff (reset)
    (!st_r.ctrl.timer_on && !count_wr) |=> $stable(st_r.count))
  else $error("Count moved while the timer was off.");

  chk_gate_opens: assert property (
    @(posedge mclk) disable iff (reset)
    (st_r.ctrl.timer_on && gated && pin_rise) |=> st_r.gate_open)
  else $error("Gate did not open on a rising edge.");

  chk_gate_closes: assert property (
    @(posedge mclk) disable iff (reset)
    gate_evt |=> !st_r.gate_open)
  else $error("Gate still open after a falling edge.");

  chk_gate_flag_set: assert property (
    @(posedge mclk) disable iff (reset)
    gate_evt |=> st_r.status[GTPI_EVT_GATE_BIT])
  else $error("Gate event did not set its flag.");

  chk_match_value: assert property (
    @(posedge mclk) disable iff (reset)
    (match_evt && !bus_req.wr) |=> st_r.count == st_r.period)
  else $error("Match event without the count at the period.");

  chk_hold_enter: assert property (
    @(posedge mclk) disable iff (reset)
    (st_r.fsm == GTPI_ST_RUN && st_r.count == st_r.period && tick_ok && hold_len != 8'h01 && !bus_req.wr) |=>
      (st_r.fsm == GTPI_ST_HOLD && $stable(st_r.count)))
  else $error("Match value not held after the match.");

  chk_resync_wait: assert property (
    @(posedge mclk) disable iff (reset)
    (st_r.fsm == GTPI_ST_RESYNC && st_r.ctrl.timer_on && !pin_rise && !bus_req.wr) |=> st_r.fsm == GTPI_ST_RESYNC)
  else $error("Resync left without a pin edge.");

  chk_claim_gated: assert property (
    @(posedge mclk) disable iff (reset)
    (st_r.ctrl.timer_on && gated) |=> gate_pin_claimed)
  else $error("Pin not claimed in gated mode.");

  chk_count_read: assert property (
    @(posedge mclk) disable iff (reset)
    ($past(bus_req.rd) && $past(bus_req.addr) == GTPI_OFS_COUNT) |-> rdata[15:0] == $past(st_r.count))
  else $error("Count read did not return the count.");

endmodule // gtpi_timer

/* File: gtpi_pkg.sv */
package gtpi_pkg;

  // Register byte offsets.
  localparam logic [7:0] GTPI_OFS_CTRL = 8'h00;
  localparam logic [7:0] GTPI_OFS_COUNT = 8'h04;
  localparam logic [7:0] GTPI_OFS_PERIOD = 8'h08;
  localparam logic [7:0] GTPI_OFS_FLAGS = 8'h0c;
  localparam logic [7:0] GTPI_OFS_ENABLE = 8'h10;
  localparam logic [7:0] GTPI_OFS_PRIO = 8'h14;

  // Field positions in the timer control word.
  localparam int GTPI_CTRL_ON_BIT = 15;
  localparam int GTPI_CTRL_GATE_BIT = 7;
  localparam int GTPI_CTRL_PS_LSB = 4;
  localparam int GTPI_CTRL_SYNC_BIT = 2;
  localparam int GTPI_CTRL_SRC_BIT = 1;

  // Field positions in the flag, enable and priority words.
  localparam int GTPI_EVT_MATCH_BIT = 0;
  localparam int GTPI_EVT_GATE_BIT = 1;
  localparam int GTPI_PRIO_LSB = 2;
  localparam int GTPI_SUBPRIO_LSB = 0;

  // Reset values and timing counts.
  localparam logic [15:0] GTPI_COUNT_RESET = 16'h0000;
  localparam logic [15:0] GTPI_PERIOD_RESET = 16'hffff;
  localparam logic [1:0] GTPI_RESYNC_TICKS = 2'h2;
  localparam logic [2:0] GTPI_PRIO_OFF = 3'h0;

  typedef enum logic [3:0] {
    GTPI_ST_IDLE = 4'b0001,
    GTPI_ST_RESYNC = 4'b0010,
    GTPI_ST_RUN = 4'b0100,
    GTPI_ST_HOLD = 4'b1000
  } gtpi_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } gtpi_bus_req_t;

  typedef struct packed {
    logic timer_on;
    logic gate_enable;
    logic [1:0] prescale_select;
    logic external_sync_enable;
    logic clock_source_select;
  } gtpi_ctrl_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } gtpi_sync_state_t;

  typedef struct packed {
    gtpi_ctrl_t ctrl;
    logic [15:0] count;
    logic [15:0] period;
    logic [1:0] status;
    logic [1:0] ie;
    logic [2:0] prio;
    logic [1:0] subprio;
    gtpi_state_t fsm;
    logic gate_open;
    logic [1:0] resync_cnt;
    logic [7:0] hold_cnt;
    logic [31:0] rdata;
    logic irq;
    logic claimed;
  } gtpi_core_state_t;

  localparam gtpi_core_state_t GTPI_CORE_RESET = '{
    ctrl: '0,
    count: GTPI_COUNT_RESET,
    period: GTPI_PERIOD_RESET,
    status: 2'h0,
    ie: 2'h0,
    prio: GTPI_PRIO_OFF,
    subprio: 2'h0,
    fsm: GTPI_ST_IDLE,
    gate_open: 1'b0,
    resync_cnt: 2'h0,
    hold_cnt: 8'h00,
    rdata: 32'h0000_0000,
    irq: 1'b0,
    claimed: 1'b0
  };

  // Division ratio selected by the two-bit prescale field.
  function automatic logic [8:0] gtpi_ratio(input logic [1:0] sel);
    case (sel)
      2'h0: gtpi_ratio = 9'h001;
      2'h1: gtpi_ratio = 9'h008;
      2'h2: gtpi_ratio = 9'h040;
      default: gtpi_ratio = 9'h100;
    endcase
  endfunction

endpackage

/* File: gtpi_gate_sync.sv */
`timescale 1ns/1ps
module gtpi_gate_sync (
  input wire logic mclk,
  input wire logic reset,
  input wire logic din,
  output logic level,
  output logic rise,
  output logic fall
);
  import gtpi_pkg::*;

  gtpi_sync_state_t st_r;
  gtpi_sync_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Edges are taken only between the second and third stages.
  assign level = st_r.s2;
  assign rise = st_r.s2 & ~st_r.s3;
  assign fall = ~st_r.s2 & st_r.s3;

  chk_sync_rise_delay: assert property (
    @(posedge mclk) disable iff (reset)
    rise |-> $past(din, 2) && !$past(din, 3))
  else $error("Gate rise not two cycles after pin rise.");

endmodule // gtpi_gate_sync

/* File: gtpi_prescale.sv */
`timescale 1ns/1ps
module gtpi_prescale #(
  parameter int CNT_W = 8
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clr,
  input wire logic tick,
  input wire logic [1:0] sel,
  output logic inc
);
  import gtpi_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } gtpi_ps_state_t;

  gtpi_ps_state_t st_r;
  gtpi_ps_state_t st_nxt;
  logic terminal;

  assign terminal = (st_r.cnt == CNT_W'(gtpi_ratio(sel) - 9'h001));
  assign inc = tick & terminal & ~clr;

  always_comb begin
    st_nxt = st_r;
    if (clr) begin
      st_nxt.cnt = '0;
    end else if (tick) begin
      st_nxt.cnt = terminal ? '0 : CNT_W'(st_r.cnt + 1'b1);
    end
  end

  // The synchronous reset doubles as the non-power-on device reset.
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  chk_prescale_clear: assert property (
    @(posedge mclk) disable iff (reset)
    clr |=> st_r.cnt == '0)
  else $error("Prescale counter not cleared.");

  chk_prescale_spacing: assert property (
    @(posedge mclk) disable iff (reset)
    (inc && sel != 2'h0) |=> !inc)
  else $error("Prescaled increments too close together.");

endmodule // gtpi_prescale

/* File: gtpi_pin_src.sv */
`timescale 1ns/1ps
module gtpi_pin_src (
  output logic pin
);
  // The source rests low between bursts, so no stray edge reaches the timer.
  initial pin = 1'b0;

  task automatic set(input logic v);
    pin <= v;
  endtask

  // The half period is not a multiple of the bus clock period, so edges drift against it.
  task automatic pulses(input int n);
    repeat (n) begin
      #370 pin <= 1'b1;
      #370 pin <= 1'b0;
    end
  endtask
endmodule // gtpi_pin_src

/* File: test_gated_timer_prescale_irq.sv */
`timescale 1ns/1ps
module test_gated_timer_prescale_irq;
  import gtpi_pkg::*;
  localparam logic [31:0] ON = 32'h1 << GTPI_CTRL_ON_BIT;
  localparam logic [31:0] GATE = 32'h1 << GTPI_CTRL_GATE_BIT;
  localparam logic [31:0] SYNC = 32'h1 << GTPI_CTRL_SYNC_BIT;
  localparam logic [31:0] EXT = (32'h1 << GTPI_CTRL_SRC_BIT) | SYNC;
  localparam logic [31:0] PS8 = 32'h1 << GTPI_CTRL_PS_LSB;
  localparam logic [31:0] MATCH = 32'h1 << GTPI_EVT_MATCH_BIT;
  localparam logic [31:0] GEVT = 32'h1 << GTPI_EVT_GATE_BIT;
  localparam logic [31:0] PRIO3 = 32'h0000_000d;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  gtpi_bus_req_t bus_req = '0;
  logic pin;
  logic [31:0] rdata;
  logic irq;
  logic gate_pin_claimed;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int k;
  int o;
  logic [31:0] v;
  logic [31:0] w;
  logic [7:0] offs [7] = '{GTPI_OFS_CTRL, GTPI_OFS_COUNT, GTPI_OFS_PERIOD, GTPI_OFS_FLAGS,
                           GTPI_OFS_ENABLE, GTPI_OFS_PRIO, 8'h20};
  logic [31:0] vals [7] = '{32'h0, 32'h0, 32'h0000_ffff, 32'h0, 32'h0, 32'h0, 32'h0};
  int nr [4] = '{1, 8, 64, 256};

  always #50 mclk = ~mclk;

  gtpi_pin_src src (.pin(pin));

  gtpi_timer dut (
    .mclk(mclk),
    .reset(reset),
    .bus_req(bus_req),
    .ext_clock_gate_pin(pin),
    .rdata(rdata),
    .irq(irq),
    .gate_pin_claimed(gate_pin_claimed)
  );

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Back-to-back count reads; hits counts reads equal to val, over counts reads above it.
  task automatic burst(input int n, input logic [15:0] val, output int hits, output int over);
    hits = 0;
    over = 0;
    @(posedge mclk);
    bus_req <= '{addr: GTPI_OFS_COUNT, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      if (i == n - 1) bus_req.rd <= 1'b0;
      #1;
      if (rdata === {16'h0, val}) hits++;
      if (rdata > {16'h0, val}) over++;
    end
  endtask

  task automatic wait_irq(input logic exp, input int lim);
    int i;
    i = 0;
    while (irq !== exp && i < lim) begin
      @(posedge mclk);
      #1 i++;
    end
    check("irq", {31'h0, exp}, {31'h0, irq});
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end

  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    foreach (offs[i]) begin
      rd(offs[i], v);
      check("reset value", vals[i], v);
    end
    check("irq", 32'h0, {31'h0, irq});
    $display("test reset done");

    wr(GTPI_OFS_PRIO, PRIO3);
    wr(GTPI_OFS_PERIOD, 32'h3);
    wr(GTPI_OFS_CTRL, ON);
    @(posedge mclk);
    #1 check("claimed", 32'h0, {31'h0, gate_pin_claimed});
    burst(12, 16'h3, k, o);
    check("period hits", 32'h3, k);
    check("above period", 32'h0, o);
    check("irq", 32'h0, {31'h0, irq});
    wr(GTPI_OFS_ENABLE, MATCH);
    wait_irq(1'b1, 3);
    wr(GTPI_OFS_PRIO, 32'h0);
    wait_irq(1'b0, 3);
    wr(GTPI_OFS_PRIO, PRIO3);
    wait_irq(1'b1, 3);
    wr(GTPI_OFS_CTRL, 32'h0);
    rd(GTPI_OFS_FLAGS, v);
    check("flags", MATCH, v);
    wait_irq(1'b0, 3);
    $display("test wrap done");

    wr(GTPI_OFS_COUNT, 32'h0);
    wr(GTPI_OFS_PERIOD, 32'h2);
    wr(GTPI_OFS_CTRL, ON | PS8);
    repeat (4) @(posedge mclk);
    burst(40, 16'h2, k, o);
    check("match hold", 32'h8, k);
    check("above period", 32'h0, o);
    $display("test hold done");

    for (int s = 0; s < 4; s++) begin
      wr(GTPI_OFS_CTRL, 32'h0);
      wr(GTPI_OFS_COUNT, 32'h0);
      wr(GTPI_OFS_PERIOD, 32'h0000_ffff);
      wr(GTPI_OFS_CTRL, ON | (32'(s) << GTPI_CTRL_PS_LSB));
      repeat (5 * nr[s] - 1) @(posedge mclk);
      wr(GTPI_OFS_CTRL, 32'h0);
      rd(GTPI_OFS_COUNT, v);
      check("prescaled count", 32'h5, v);
    end
    $display("test prescale done");

    rd(GTPI_OFS_FLAGS, v);
    wr(GTPI_OFS_ENABLE, 32'h0);
    wr(GTPI_OFS_COUNT, 32'h0);
    wr(GTPI_OFS_PERIOD, 32'h4);
    wr(GTPI_OFS_CTRL, ON | GATE | SYNC);
    @(posedge mclk);
    #1 check("claimed", 32'h1, {31'h0, gate_pin_claimed});
    repeat (10) @(posedge mclk);
    rd(GTPI_OFS_COUNT, v);
    check("closed gate count", 32'h0, v);
    src.set(1'b1);
    repeat (13) @(posedge mclk);
    src.set(1'b0);
    repeat (6) @(posedge mclk);
    rd(GTPI_OFS_COUNT, v);
    repeat (4) @(posedge mclk);
    rd(GTPI_OFS_COUNT, w);
    check("held count", v, w);
    check("count in period", 32'h1, {31'h0, (v <= 4)});
    check("irq", 32'h0, {31'h0, irq});
    wr(GTPI_OFS_ENABLE, GEVT);
    wait_irq(1'b1, 3);
    rd(GTPI_OFS_FLAGS, v);
    check("flags", GEVT, v);
    wait_irq(1'b0, 3);
    wr(GTPI_OFS_COUNT, 32'h0);
    rd(GTPI_OFS_COUNT, v);
    check("cleared count", 32'h0, v);
    $display("test gate done");

    wr(GTPI_OFS_CTRL, 32'h0);
    wr(GTPI_OFS_PERIOD, 32'h0000_ffff);
    wr(GTPI_OFS_CTRL, ON | EXT | PS8);
    @(posedge mclk);
    #1 check("claimed", 32'h1, {31'h0, gate_pin_claimed});
    src.pulses(18);
    repeat (4) @(posedge mclk);
    rd(GTPI_OFS_COUNT, v);
    check("external count", 32'h2, v);
    wr(GTPI_OFS_CTRL, 32'h0);
    repeat (3) @(posedge mclk);
    check("claimed", 32'h0, {31'h0, gate_pin_claimed});
    $display("test external done");
    results();
  end
endmodule // test_gated_timer_prescale_irq
